// ### hw/iosb_pkg.sv
// package: constants, register map and encodings for the increment/or/shift/branch slice
package iosb_pkg;
  // =====================================================================
  // apb register byte offsets
  localparam logic [7:0] IOSB_OFF_INSTR = 8'h00;
  localparam logic [7:0] IOSB_OFF_ACCUM = 8'h04;
  localparam logic [7:0] IOSB_OFF_STATUS = 8'h08;
  localparam logic [7:0] IOSB_OFF_PC = 8'h0c;
  localparam logic [7:0] IOSB_OFF_PAGE = 8'h10;
  localparam logic [7:0] IOSB_OFF_BANK = 8'h14;
  localparam logic [7:0] IOSB_OFF_FADDR = 8'h18;
  localparam logic [7:0] IOSB_OFF_FDATA = 8'h1c;
  localparam logic [7:0] IOSB_OFF_CYCLES = 8'h20;

  // =====================================================================
  // field positions
  localparam int IOSB_INSTR_K_LSB = 0;
  localparam int IOSB_INSTR_F_LSB = 16;
  localparam int IOSB_INSTR_D_BIT = 23;
  localparam int IOSB_INSTR_OP_LSB = 24;
  localparam int IOSB_ST_C_BIT = 0;
  localparam int IOSB_ST_Z_BIT = 1;
  localparam int IOSB_ST_BUSY_BIT = 2;
  localparam int IOSB_JUMP_K_W = 11;
  localparam int IOSB_PAGE_JUMP_LSB = 3;
  localparam int IOSB_PC_W = 15;
  localparam int IOSB_FILE_AW = 7;
  localparam int IOSB_PAGE_W = 7;

  // =====================================================================
  // reset values and timing
  localparam logic [7:0] IOSB_ACCUM_RST = 8'h00;
  localparam logic [14:0] IOSB_PC_RST = 15'h0000;
  localparam logic [6:0] IOSB_PAGE_RST = 7'h00;
  localparam int IOSB_CLK_MHZ = 125;
  localparam int IOSB_INSN_CYC_NS = 200;
  localparam int IOSB_INSN_DIV = (IOSB_INSN_CYC_NS * IOSB_CLK_MHZ) / 1000;

  // =====================================================================
  // operation codes and sequencer states
  typedef enum logic [2:0] {
    IOSB_OP_INCREMENT_SKIP_ON_ZERO = 3'b000,
    IOSB_OP_INCREMENT_REGISTER = 3'b001,
    IOSB_OP_ABSOLUTE_JUMP = 3'b010,
    IOSB_OP_OR_ACCUMULATOR_LITERAL = 3'b011,
    IOSB_OP_OR_ACCUMULATOR_REGISTER = 3'b100,
    IOSB_OP_LOGICAL_SHIFT_LEFT = 3'b101,
    IOSB_OP_NOP6 = 3'b110,
    IOSB_OP_NOP7 = 3'b111
  } iosb_op_e;

  typedef enum logic [1:0] {
    IOSB_ST_IDLE = 2'b00,
    IOSB_ST_SKIP_NOP = 2'b01,
    IOSB_ST_JUMP_FLUSH = 2'b10
  } iosb_state_e;
endpackage : iosb_pkg

// ### hw/iosb_alu.sv
// combinational result and flag logic for one executed operation
`timescale 1ns/1ps
`default_nettype none
module iosb_alu
  import iosb_pkg::*;
(
  input wire iosb_op_e op,
  input wire logic [7:0] accum,
  input wire logic [7:0] fval,
  input wire logic [7:0] literal,
  input wire logic dest_bit,
  output logic [7:0] result,
  output logic carry_out,
  output logic zero_out,
  output logic upd_carry,
  output logic upd_zero,
  output logic write_file,
  output logic write_accum
);
  // =====================================================================
  // result, destination and flag selection
  always_comb begin
    result = 8'h00;
    carry_out = 1'b0;
    upd_carry = 1'b0;
    upd_zero = 1'b0;
    write_file = 1'b0;
    write_accum = 1'b0;
    case (op)
      IOSB_OP_INCREMENT_SKIP_ON_ZERO: begin
        result = fval + 8'h01;
        write_file = dest_bit;
        write_accum = !dest_bit;
      end
      IOSB_OP_INCREMENT_REGISTER: begin
        result = fval + 8'h01;
        upd_zero = 1'b1;
        write_file = dest_bit;
        write_accum = !dest_bit;
      end
      IOSB_OP_OR_ACCUMULATOR_LITERAL: begin
        result = accum | literal;
        upd_zero = 1'b1;
        write_accum = 1'b1;
      end
      IOSB_OP_OR_ACCUMULATOR_REGISTER: begin
        result = accum | fval;
        upd_zero = 1'b1;
        write_file = dest_bit;
        write_accum = !dest_bit;
      end
      IOSB_OP_LOGICAL_SHIFT_LEFT: begin
        result = {fval[6:0], 1'b0};
        carry_out = fval[7];
        upd_carry = 1'b1;
        upd_zero = 1'b1;
        write_file = dest_bit;
        write_accum = !dest_bit;
      end
      default: begin
        result = 8'h00;
      end
    endcase
  end

  assign zero_out = (result == 8'h00);
endmodule : iosb_alu
`default_nettype wire

// ### hw/iosb_core.sv
// increment, or, shift and absolute jump execution slice with an apb register port
// Behaviour
// - increment-skip adds one to the file register, writes destination, flags untouched
// - nonzero increment-skip sum runs the next instruction normally, no extra cycle
// - zero increment-skip sum turns the next slot into a nop, two cycles total
// - destination bit 0 writes the accumulator, 1 writes back the file register
// - plain increment adds one, routes by destination bit, updates zero only
// - absolute jump loads pc bits 10..0 from the 11-bit immediate, flags untouched
// - absolute jump loads pc bits 14..11 from page latch bits 6..3
// - every absolute jump takes two instruction cycles
// - or-literal ors accumulator with 8-bit immediate into accumulator, updates zero
// - or-register ors accumulator with file register, routes by destination, updates zero
// - left shift moves bit 7 to carry, bits 6..0 up, updates carry and zero
// - left shift forces result bit 0 low and routes by destination bit
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module iosb_core
  import iosb_pkg::*;
#(
  parameter int BANK_W = 5,
  parameter int INSN_DIV = IOSB_INSN_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [14:0] pc_out,
  output logic [7:0] accum_out,
  output logic carry_out,
  output logic zero_out,
  output logic busy
);
  localparam int MEM_DEPTH = (1 << (BANK_W + IOSB_FILE_AW));
  localparam int MEM_AW = BANK_W + IOSB_FILE_AW;

  // =====================================================================
  // state
  logic [7:0] file_mem [MEM_DEPTH];
  logic [7:0] accum_reg, accum_next;
  logic carry_reg, carry_next;
  logic zero_reg, zero_next;
  logic [14:0] pc_reg, pc_next;
  logic [6:0] page_reg, page_next;
  logic [BANK_W-1:0] bank_reg, bank_next;
  logic [6:0] faddr_reg, faddr_next;
  logic [31:0] instr_reg, instr_next;
  logic pending_reg, pending_next;
  iosb_state_e state_reg, state_next;
  logic [31:0] cycles_reg, cycles_next;
  logic [7:0] div_reg, div_next;
  logic tick_reg, tick_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic busy_reg, busy_next;

  // =====================================================================
  // decode of the pending instruction
  iosb_op_e op;
  logic dest_bit;
  logic [6:0] f_addr;
  logic [10:0] k_field;
  logic [MEM_AW-1:0] exec_addr;
  logic [7:0] fval;
  logic [7:0] alu_result;
  logic alu_carry, alu_zero, alu_upd_c, alu_upd_z, alu_wr_f, alu_wr_w;

  assign op = iosb_op_e'(instr_reg[IOSB_INSTR_OP_LSB +: 3]);
  assign dest_bit = instr_reg[IOSB_INSTR_D_BIT];
  assign f_addr = instr_reg[IOSB_INSTR_F_LSB +: IOSB_FILE_AW];
  assign k_field = instr_reg[IOSB_INSTR_K_LSB +: IOSB_JUMP_K_W];
  assign exec_addr = {bank_reg, f_addr};
  assign fval = file_mem[exec_addr];

  iosb_alu u_alu (
    .op(op),
    .accum(accum_reg),
    .fval(fval),
    .literal(k_field[7:0]),
    .dest_bit(dest_bit),
    .result(alu_result),
    .carry_out(alu_carry),
    .zero_out(alu_zero),
    .upd_carry(alu_upd_c),
    .upd_zero(alu_upd_z),
    .write_file(alu_wr_f),
    .write_accum(alu_wr_w)
  );

  // =====================================================================
  // instruction-cycle divider: one pclk pulse per instruction cycle
  always_comb begin
    div_next = div_reg + 8'h01;
    tick_next = 1'b0;
    if (div_reg == 8'(INSN_DIV - 1)) begin
      div_next = 8'h00;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 8'h00;
      tick_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      tick_reg <= tick_next;
    end
  end

  // =====================================================================
  // apb decode
  logic apb_access;
  logic apb_mapped;
  logic apb_wr_ok;
  logic apb_do_write;
  logic [31:0] rd_mux;

  assign apb_access = psel && penable;
  // writes wait while an instruction is in flight so software and the
  // executor never modify the same state in one cycle
  assign apb_wr_ok = !pwrite || !busy_reg;
  assign apb_do_write = apb_access && pready_reg && pwrite && apb_mapped;

  always_comb begin
    apb_mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      IOSB_OFF_INSTR: rd_mux = instr_reg;
      IOSB_OFF_ACCUM: rd_mux = {24'h00_0000, accum_reg};
      IOSB_OFF_STATUS: rd_mux = {29'h0000_0000, busy_reg, zero_reg, carry_reg};
      IOSB_OFF_PC: rd_mux = {17'h0_0000, pc_reg};
      IOSB_OFF_PAGE: rd_mux = {25'h000_0000, page_reg};
      IOSB_OFF_BANK: rd_mux = 32'(bank_reg);
      IOSB_OFF_FADDR: rd_mux = {25'h000_0000, faddr_reg};
      IOSB_OFF_FDATA: rd_mux = {24'h00_0000, file_mem[{bank_reg, faddr_reg}]};
      IOSB_OFF_CYCLES: rd_mux = cycles_reg;
      default: apb_mapped = 1'b0;
    endcase
  end

  // one wait state: pready rises the cycle after the access phase begins
  always_comb begin
    pready_next = 1'b0;
    prdata_next = prdata_reg;
    pslverr_next = 1'b0;
    if (apb_access && !pready_reg && apb_wr_ok) begin
      pready_next = 1'b1;
      prdata_next = pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_next = !apb_mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= pready_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // =====================================================================
  // sequencer and architectural state
  logic mem_we;
  logic [MEM_AW-1:0] mem_waddr;
  logic [7:0] mem_wdata;

  always_comb begin
    accum_next = accum_reg;
    carry_next = carry_reg;
    zero_next = zero_reg;
    pc_next = pc_reg;
    page_next = page_reg;
    bank_next = bank_reg;
    faddr_next = faddr_reg;
    instr_next = instr_reg;
    pending_next = pending_reg;
    state_next = state_reg;
    cycles_next = cycles_reg;
    mem_we = 1'b0;
    mem_waddr = {bank_reg, faddr_reg};
    mem_wdata = pwdata[7:0];

    if (apb_do_write) begin
      case (paddr)
        IOSB_OFF_INSTR: begin
          instr_next = pwdata;
          pending_next = 1'b1;
        end
        IOSB_OFF_ACCUM: accum_next = pwdata[7:0];
        IOSB_OFF_STATUS: begin
          carry_next = pwdata[IOSB_ST_C_BIT];
          zero_next = pwdata[IOSB_ST_Z_BIT];
        end
        IOSB_OFF_PC: pc_next = pwdata[IOSB_PC_W-1:0];
        IOSB_OFF_PAGE: page_next = pwdata[IOSB_PAGE_W-1:0];
        IOSB_OFF_BANK: bank_next = pwdata[BANK_W-1:0];
        IOSB_OFF_FADDR: faddr_next = pwdata[IOSB_FILE_AW-1:0];
        IOSB_OFF_FDATA: mem_we = 1'b1;
        default: ;
      endcase
    end else if (tick_reg) begin
      case (state_reg)
        IOSB_ST_IDLE: begin
          if (pending_reg) begin
            pending_next = 1'b0;
            cycles_next = cycles_reg + 32'h0000_0001;
            if (op == IOSB_OP_ABSOLUTE_JUMP) begin
              // operation row wins over the prose: page latch 6..3 feeds 14..11
              pc_next = {page_reg[IOSB_PAGE_JUMP_LSB +: 4], k_field};
              state_next = IOSB_ST_JUMP_FLUSH;
            end else begin
              pc_next = pc_reg + 15'h0001;
              if (alu_wr_w) begin
                accum_next = alu_result;
              end
              if (alu_wr_f) begin
                mem_we = 1'b1;
                mem_waddr = exec_addr;
                mem_wdata = alu_result;
              end
              if (alu_upd_z) begin
                zero_next = alu_zero;
              end
              if (alu_upd_c) begin
                carry_next = alu_carry;
              end
              // a nonzero sum stays idle so the next issue costs no extra cycle
              if (op == IOSB_OP_INCREMENT_SKIP_ON_ZERO && alu_zero) begin
                state_next = IOSB_ST_SKIP_NOP;
              end else begin
                state_next = IOSB_ST_IDLE;
              end
            end
          end
        end
        IOSB_ST_SKIP_NOP: begin
          // the skipped slot: pc steps over the next word and the cycle count rises, nothing else moves
          pc_next = pc_reg + 15'h0001;
          cycles_next = cycles_reg + 32'h0000_0001;
          state_next = IOSB_ST_IDLE;
        end
        IOSB_ST_JUMP_FLUSH: begin
          cycles_next = cycles_reg + 32'h0000_0001;
          state_next = IOSB_ST_IDLE;
        end
        default: state_next = IOSB_ST_IDLE;
      endcase
    end
  end

  assign busy_next = pending_next || (state_next != IOSB_ST_IDLE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accum_reg <= IOSB_ACCUM_RST;
      carry_reg <= 1'b0;
      zero_reg <= 1'b0;
      pc_reg <= IOSB_PC_RST;
      page_reg <= IOSB_PAGE_RST;
      bank_reg <= '0;
      faddr_reg <= 7'h00;
      instr_reg <= 32'h0000_0000;
      pending_reg <= 1'b0;
      state_reg <= IOSB_ST_IDLE;
      cycles_reg <= 32'h0000_0000;
      busy_reg <= 1'b0;
    end else begin
      accum_reg <= accum_next;
      carry_reg <= carry_next;
      zero_reg <= zero_next;
      pc_reg <= pc_next;
      page_reg <= page_next;
      bank_reg <= bank_next;
      faddr_reg <= faddr_next;
      instr_reg <= instr_next;
      pending_reg <= pending_next;
      state_reg <= state_next;
      cycles_reg <= cycles_next;
      busy_reg <= busy_next;
    end
  end

  // data memory holds no reset value, like real file ram
  always_ff @(posedge pclk) begin
    if (mem_we) begin
      file_mem[mem_waddr] <= mem_wdata;
    end
  end

  // =====================================================================
  // outputs straight from flops
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign pc_out = pc_reg;
  assign accum_out = accum_reg;
  assign carry_out = carry_reg;
  assign zero_out = zero_reg;
  assign busy = busy_reg;
endmodule : iosb_core
`default_nettype wire

// ### test/iosb_core_sva.sv
// port-level checker for the execution slice
`timescale 1ns/1ps
`default_nettype none
module iosb_core_sva
  import iosb_pkg::*;
#(
  parameter int INSN_DIV = IOSB_INSN_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [14:0] pc_out,
  input wire logic [7:0] accum_out,
  input wire logic carry_out,
  input wire logic zero_out,
  input wire logic busy
);
  // =====================================================================
  // helpers
  // a two-cycle operation may arrive just after a tick, so allow three ticks
  localparam int BUSY_MAX = 3 * INSN_DIV + 2;
  logic wr_done;
  assign wr_done = pready && pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // =====================================================================
  // bus answer
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held over one cycle");
  chk_ready_access: assert property (pready |-> psel && penable && $past(psel))
    else $error("pready outside an access phase");
  chk_err_ready: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error answer malformed");
  chk_write_rdata: assert property (wr_done |-> prdata == 32'h0000_0000)
    else $error("read data on a write");
  chk_write_stall: assert property (wr_done |-> !$past(busy))
    else $error("write accepted while busy");

  // =====================================================================
  // execution
  chk_busy_cause: assert property ($rose(busy) |-> $past(wr_done && paddr == IOSB_OFF_INSTR))
    else $error("busy without an instruction write");
  chk_busy_bound: assert property ($rose(busy) |-> ##[1:BUSY_MAX] !busy)
    else $error("instruction never completed");
  chk_pc_hold: assert property (!busy && !wr_done |=> $stable(pc_out))
    else $error("pc moved while idle");
  chk_flag_hold: assert property (!busy && !wr_done |=> $stable({carry_out, zero_out}))
    else $error("flags moved while idle");
  chk_accum_hold: assert property (!busy && !wr_done |=> $stable(accum_out))
    else $error("accumulator moved while idle");

  cover_exec: cover property ($fell(busy));
  cover_err: cover property (pslverr);
  cover_write: cover property (wr_done && paddr == IOSB_OFF_INSTR);
endmodule : iosb_core_sva
`default_nettype wire

// ### test/testbench.sv
// self-checking bench for the execution slice
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import iosb_pkg::*;
  localparam int INSN_DIV = 4;
  logic pclk, presetn, psel, penable, pwrite, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, carry_out, zero_out, busy;
  logic [14:0] pc_out;
  logic [7:0] accum_out;
  int num_errors = 0;
  int check_count = 0;
  int cyc = 0;

  iosb_core #(.INSN_DIV(INSN_DIV)) i_iosb_core (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pc_out(pc_out), .accum_out(accum_out),
    .carry_out(carry_out), .zero_out(zero_out), .busy(busy)
  );

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // =====================================================================
  // shared tasks
  task end_of_test;
    if (num_errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // idle cycle after each transfer keeps psel from being assigned twice at one edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask : rdchk

  task automatic setf(input logic [6:0] f, input logic [7:0] v);
    apb(1'b1, IOSB_OFF_FADDR, {25'h000_0000, f});
    apb(1'b1, IOSB_OFF_FDATA, {24'h00_0000, v});
  endtask : setf

  task automatic getf(input logic [6:0] f, input logic [7:0] e);
    apb(1'b1, IOSB_OFF_FADDR, {25'h000_0000, f});
    rdchk(IOSB_OFF_FDATA, {24'h00_0000, e});
  endtask : getf

  function automatic logic [31:0] mk(iosb_op_e op, logic d, logic [6:0] f, logic [10:0] k);
    return {5'h00, op, d, f, 5'h00, k};
  endfunction : mk

  // pc starts at 0x100 so skip and jump targets are absolute
  task automatic run(input logic [31:0] ins, input logic [7:0] a0, input logic [1:0] s0,
    input logic [7:0] ea, input logic [1:0] es, input logic [14:0] epc,
    input logic [31:0] ec);
    logic [31:0] c0;
    apb(1'b1, IOSB_OFF_ACCUM, {24'h00_0000, a0});
    apb(1'b1, IOSB_OFF_STATUS, {30'h0000_0000, s0});
    apb(1'b1, IOSB_OFF_PC, 32'h0000_0100);
    apb(1'b0, IOSB_OFF_CYCLES, 32'h0000_0000);
    c0 = rd;
    apb(1'b1, IOSB_OFF_INSTR, ins);
    while (busy !== 1'b0) @(posedge pclk);
    chk({24'h00_0000, accum_out}, {24'h00_0000, ea});
    chk({30'h0000_0000, zero_out, carry_out}, {30'h0000_0000, es});
    chk({17'h0_0000, pc_out}, {17'h0_0000, epc});
    rdchk(IOSB_OFF_ACCUM, {24'h00_0000, ea});
    rdchk(IOSB_OFF_STATUS, {30'h0000_0000, es});
    rdchk(IOSB_OFF_PC, {17'h0_0000, epc});
    apb(1'b0, IOSB_OFF_CYCLES, 32'h0000_0000);
    chk(rd, c0 + ec);
  endtask : run

  // =====================================================================
  // scenarios
  task t_reset;
    rdchk(IOSB_OFF_ACCUM, 32'h0000_0000);
    rdchk(IOSB_OFF_STATUS, 32'h0000_0000);
    rdchk(IOSB_OFF_PC, 32'h0000_0000);
    rdchk(IOSB_OFF_PAGE, 32'h0000_0000);
    rdchk(IOSB_OFF_CYCLES, 32'h0000_0000);
  endtask : t_reset

  task t_skip;
    setf(7'h05, 8'h41);
    run(mk(IOSB_OP_INCREMENT_SKIP_ON_ZERO, 1'b1, 7'h05, 11'h000), 8'h33, 2'h3,
      8'h33, 2'h3, 15'h0101, 32'h0000_0001);
    getf(7'h05, 8'h42);
    setf(7'h06, 8'hff);
    run(mk(IOSB_OP_INCREMENT_SKIP_ON_ZERO, 1'b0, 7'h06, 11'h000), 8'h5a, 2'h0,
      8'h00, 2'h0, 15'h0102, 32'h0000_0002);
    getf(7'h06, 8'hff);
  endtask : t_skip

  task t_incr;
    setf(7'h07, 8'hff);
    run(mk(IOSB_OP_INCREMENT_REGISTER, 1'b1, 7'h07, 11'h000), 8'h11, 2'h1,
      8'h11, 2'h3, 15'h0101, 32'h0000_0001);
    getf(7'h07, 8'h00);
    run(mk(IOSB_OP_INCREMENT_REGISTER, 1'b0, 7'h07, 11'h000), 8'h11, 2'h3,
      8'h01, 2'h1, 15'h0101, 32'h0000_0001);
    // an accumulator write right behind an instruction must wait for it to finish
    apb(1'b1, IOSB_OFF_INSTR, mk(IOSB_OP_INCREMENT_REGISTER, 1'b0, 7'h07, 11'h000));
    apb(1'b1, IOSB_OFF_ACCUM, 32'h0000_0077);
    chk({31'h0000_0000, busy}, 32'h0000_0000);
    rdchk(IOSB_OFF_ACCUM, 32'h0000_0077);
  endtask : t_incr

  task t_jump;
    apb(1'b1, IOSB_OFF_PAGE, 32'h0000_0047);
    run(mk(IOSB_OP_ABSOLUTE_JUMP, 1'b0, 7'h00, 11'h000), 8'h22, 2'h3,
      8'h22, 2'h3, 15'h4000, 32'h0000_0002);
    apb(1'b1, IOSB_OFF_PAGE, 32'h0000_0038);
    run(mk(IOSB_OP_ABSOLUTE_JUMP, 1'b0, 7'h00, 11'h7ff), 8'h22, 2'h0,
      8'h22, 2'h0, 15'h3fff, 32'h0000_0002);
  endtask : t_jump

  task t_or;
    run(mk(IOSB_OP_OR_ACCUMULATOR_LITERAL, 1'b0, 7'h00, 11'h000), 8'h00, 2'h0,
      8'h00, 2'h2, 15'h0101, 32'h0000_0001);
    run(mk(IOSB_OP_OR_ACCUMULATOR_LITERAL, 1'b0, 7'h00, 11'h081), 8'h04, 2'h3,
      8'h85, 2'h1, 15'h0101, 32'h0000_0001);
    run(mk(IOSB_OP_NOP6, 1'b0, 7'h08, 11'h0ff), 8'h5a, 2'h3,
      8'h5a, 2'h3, 15'h0101, 32'h0000_0001);
    setf(7'h08, 8'h14);
    run(mk(IOSB_OP_OR_ACCUMULATOR_REGISTER, 1'b1, 7'h08, 11'h000), 8'h81, 2'h2,
      8'h81, 2'h0, 15'h0101, 32'h0000_0001);
    getf(7'h08, 8'h95);
    setf(7'h09, 8'h00);
    run(mk(IOSB_OP_OR_ACCUMULATOR_REGISTER, 1'b0, 7'h09, 11'h000), 8'h00, 2'h1,
      8'h00, 2'h3, 15'h0101, 32'h0000_0001);
  endtask : t_or

  task t_shift;
    setf(7'h0a, 8'h81);
    run(mk(IOSB_OP_LOGICAL_SHIFT_LEFT, 1'b0, 7'h0a, 11'h000), 8'h00, 2'h2,
      8'h02, 2'h1, 15'h0101, 32'h0000_0001);
    setf(7'h7f, 8'h80);
    run(mk(IOSB_OP_LOGICAL_SHIFT_LEFT, 1'b1, 7'h7f, 11'h000), 8'h55, 2'h0,
      8'h55, 2'h3, 15'h0101, 32'h0000_0001);
    getf(7'h7f, 8'h00);
    setf(7'h0b, 8'h40);
    run(mk(IOSB_OP_LOGICAL_SHIFT_LEFT, 1'b0, 7'h0b, 11'h000), 8'h00, 2'h3,
      8'h80, 2'h0, 15'h0101, 32'h0000_0001);
  endtask : t_shift

  task t_bad_bank;
    apb(1'b0, 8'h24, 32'h0000_0000);
    chk(err, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    apb(1'b1, 8'h40, 32'h0000_00ff);
    chk(err, 32'h0000_0001);
    apb(1'b1, IOSB_OFF_BANK, 32'h0000_0001);
    setf(7'h05, 8'h99);
    apb(1'b1, IOSB_OFF_BANK, 32'h0000_0000);
    getf(7'h05, 8'h42);
    apb(1'b1, IOSB_OFF_BANK, 32'h0000_0001);
    getf(7'h05, 8'h99);
  endtask : t_bad_bank

  // =====================================================================
  // main sequence and hang guard
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_skip;
    t_incr;
    t_jump;
    t_or;
    t_shift;
    t_bad_bank;
    end_of_test;
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      end_of_test;
    end
  end
endmodule : testbench

bind iosb_core iosb_core_sva #(.INSN_DIV(INSN_DIV)) u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pc_out(pc_out), .accum_out(accum_out),
  .carry_out(carry_out), .zero_out(zero_out), .busy(busy)
);
`default_nettype wire
